// [brxs_pkg.sv]
// Contract
// - The long-preamble scrambler seed is held in bits 6:0 and offered through the seed-select choice.
// - The short-preamble scrambler seed is held in bits 6:0 of the seed-and-view register.
// - Bit 7 of the seed-and-view register picks the read-only view, 1 for 'a' and 0 for 'b'.
// - The test bus register returns the live internal test bus value in both views.
// - Register 51 returns the antenna one noise level in view 'a'.
// - Register 51 returns the tracking-loop signal quality in view 'b'.
// - Register 52 returns the antenna two noise level in view 'a' and the signal field in view 'b'.
// - Register 53 returns the I DC offset in view 'a' and the service field in view 'b'.
// - Register 54 returns the Q DC offset in view 'a' and the length low byte in view 'b'.
// - Register 55 returns the last packet multipath metric in view 'a' and length high byte in 'b'.
// - Register 56 counts last 15 packets over the multipath threshold in 'a', header CRC low in 'b'.
// - Register 57 returns packet quality in 'a', read after receive processing ends, CRC high in 'b'.
// - Register 58 returns the signed transmit power averaged over 64 samples in both views.
// - A semaphore is set whenever the power average updates and cleared when register 58 is read.
package brxs_pkg;

	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int BRXS_AW = 12;
	localparam int BRXS_IW = BRXS_AW - 2;

	// ------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [9:0] BRXS_IDX_LONG_SEED = 10'h060;
	localparam logic [9:0] BRXS_IDX_SHORT_VIEW = 10'h062;
	localparam logic [9:0] BRXS_IDX_TEST_BUS = 10'h064;
	localparam logic [9:0] BRXS_IDX_QUAL_NOISE_A = 10'h066;
	localparam logic [9:0] BRXS_IDX_SIG_NOISE_B = 10'h068;
	localparam logic [9:0] BRXS_IDX_SERV_I_OFF = 10'h06a;
	localparam logic [9:0] BRXS_IDX_LENL_Q_OFF = 10'h06c;
	localparam logic [9:0] BRXS_IDX_LENH_MP = 10'h06e;
	localparam logic [9:0] BRXS_IDX_CRCL_MPCNT = 10'h070;
	localparam logic [9:0] BRXS_IDX_CRCH_QUAL = 10'h072;
	localparam logic [9:0] BRXS_IDX_TX_POWER = 10'h074;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int BRXS_VIEW_BIT = 7;
	localparam int BRXS_MP_HIST = 15;
	localparam logic [7:0] BRXS_SEED_RST = 8'h00;
	localparam logic [7:0] BRXS_MEAS_RST = 8'h00;
	localparam logic [5:0] BRXS_AVG_LAST = 6'h3f;
	localparam int BRXS_AVG_SHIFT = 6;

	// Receive measurements from the baseband datapath, same clock
	typedef struct packed {
		logic [7:0] noise_a;
		logic [7:0] noise_b;
		logic [7:0] i_offset;
		logic [7:0] q_offset;
		logic [7:0] loop_quality;
		logic [7:0] signal_field;
		logic [7:0] service_field;
		logic [15:0] length_field;
		logic [15:0] header_crc;
		logic [7:0] packet_quality;
	} brxs_meas_t;

endpackage

// [brxs_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module brxs_regs
	import brxs_pkg::*;
(
	input wire logic pclk, // 250 MHz bus clock
	input wire logic presetn, // Async reset, active low
	input wire logic clk_en, // Freezes all state when low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [BRXS_AW-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data, registered
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [7:0] test_bus, // Internal test bus
	input wire brxs_meas_t meas, // Receive measurements
	input wire logic packet_done, // Pulse at end of each packet
	input wire logic [7:0] mp_metric, // Multipath metric of that packet
	input wire logic [2:0] mp_threshold, // From multipath_threshold_reg
	input wire logic signed [7:0] tx_sample, // Transmit power sample
	input wire logic tx_sample_valid, // Sample strobe
	input wire logic seed_select, // From seed_select_control_reg
	output logic [6:0] active_seed, // Seed handed to the scrambler
	output logic view_a, // Read-only view is 'a'
	output logic tx_power_updated // Semaphore for receive_status_reg
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] brxs_popcount(input logic [14:0] v);
		logic [3:0] sum;
		sum = 4'h0;
		for (int i = 0; i < BRXS_MP_HIST; i++)
		begin
			sum = sum + {3'h0, v[i]};
		end
		return sum;
	endfunction

	function automatic logic signed [13:0] brxs_sext(input logic [7:0] s);
		return {{6{s[7]}}, s};
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] long_seed;
	logic [7:0] short_view;
	logic [7:0] mp_last;
	logic [14:0] mp_hist;
	logic signed [13:0] tx_acc;
	logic [5:0] tx_cnt;
	logic [7:0] tx_avg;
	logic sem;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire [BRXS_IW-1:0] idx = paddr[BRXS_AW-1:2];
	wire aligned = paddr[1:0] == 2'b00;
	wire hit_long = aligned && idx == BRXS_IDX_LONG_SEED;
	wire hit_short = aligned && idx == BRXS_IDX_SHORT_VIEW;
	wire hit_test = aligned && idx == BRXS_IDX_TEST_BUS;
	wire hit_51 = aligned && idx == BRXS_IDX_QUAL_NOISE_A;
	wire hit_52 = aligned && idx == BRXS_IDX_SIG_NOISE_B;
	wire hit_53 = aligned && idx == BRXS_IDX_SERV_I_OFF;
	wire hit_54 = aligned && idx == BRXS_IDX_LENL_Q_OFF;
	wire hit_55 = aligned && idx == BRXS_IDX_LENH_MP;
	wire hit_56 = aligned && idx == BRXS_IDX_CRCL_MPCNT;
	wire hit_57 = aligned && idx == BRXS_IDX_CRCH_QUAL;
	wire hit_58 = aligned && idx == BRXS_IDX_TX_POWER;
	wire hit_ro = hit_test || hit_51 || hit_52 || hit_53 || hit_54 ||
		hit_55 || hit_56 || hit_57 || hit_58;
	wire mapped = hit_long || hit_short || hit_ro;

	// Stalling on clk_en keeps a frozen block from completing transfers
	assign pready = clk_en;
	assign pslverr = psel && penable && !mapped;

	wire setup_rd = psel && !penable && !pwrite && clk_en;
	wire acc_done = psel && penable && pready;
	wire wr_en = acc_done && pwrite && pstrb[0];
	wire rd_done = acc_done && !pwrite;

	// ------------------------------------------------------------
	// Seeds and view select
	// ------------------------------------------------------------
	wire view_sel = short_view[BRXS_VIEW_BIT];
	assign view_a = view_sel;
	// Bit 7 of the long seed is kept for readback only
	assign active_seed = seed_select ? long_seed[6:0] : short_view[6:0];

	// Software writes land only at the completing access edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			long_seed <= BRXS_SEED_RST;
			short_view <= BRXS_SEED_RST;
		end
		else if (clk_en)
		begin
			if (wr_en && hit_long)
				long_seed <= pwdata[7:0];
			if (wr_en && hit_short)
				short_view <= pwdata[7:0];
		end
	end

	// ------------------------------------------------------------
	// Multipath history over the last packets
	// ------------------------------------------------------------
	// Metric top three bits are compared against the 3-bit threshold
	wire mp_over = mp_metric[7:5] > mp_threshold;
	wire [3:0] mp_count = brxs_popcount(mp_hist);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mp_last <= BRXS_MEAS_RST;
			mp_hist <= 15'h0000;
		end
		else if (clk_en && packet_done)
		begin
			mp_last <= mp_metric;
			mp_hist <= {mp_hist[13:0], mp_over};
		end
	end

	// ------------------------------------------------------------
	// Transmit power average over 64 samples
	// ------------------------------------------------------------
	// 14-bit sum holds 64 signed bytes; floor division by shifting
	wire signed [13:0] next_acc = tx_acc + brxs_sext(tx_sample);
	wire avg_done = clk_en && tx_sample_valid && tx_cnt == BRXS_AVG_LAST;
	wire sem_clr = clk_en && rd_done && hit_58;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_acc <= 14'sh0000;
			tx_cnt <= 6'h00;
			tx_avg <= BRXS_MEAS_RST;
		end
		else if (clk_en && tx_sample_valid)
		begin
			tx_cnt <= tx_cnt + 6'h01;
			if (tx_cnt == BRXS_AVG_LAST)
			begin
				tx_avg <= next_acc[13:BRXS_AVG_SHIFT];
				tx_acc <= 14'sh0000;
			end
			else
				tx_acc <= next_acc;
		end
	end

	// An update in the same cycle as the clearing read keeps the flag set
	wire next_sem = avg_done || (sem && !sem_clr);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sem <= 1'b0;
		else if (clk_en)
			sem <= next_sem;
	end

	assign tx_power_updated = sem;

	// ------------------------------------------------------------
	// Read data selection
	// ------------------------------------------------------------
	// Packet quality is only meaningful once receive processing is idle
	wire [7:0] rd_51 = view_sel ? meas.noise_a : meas.loop_quality;
	wire [7:0] rd_52 = view_sel ? meas.noise_b : meas.signal_field;
	wire [7:0] rd_53 = view_sel ? meas.i_offset : meas.service_field;
	wire [7:0] rd_54 = view_sel ? meas.q_offset : meas.length_field[7:0];
	wire [7:0] rd_55 = view_sel ? mp_last : meas.length_field[15:8];
	wire [7:0] rd_56 = view_sel ? {4'h0, mp_count} : meas.header_crc[7:0];
	wire [7:0] rd_57 = view_sel ? meas.packet_quality : meas.header_crc[15:8];
	wire [7:0] rd_val =
		hit_long ? long_seed :
		hit_short ? short_view :
		hit_test ? test_bus :
		hit_51 ? rd_51 :
		hit_52 ? rd_52 :
		hit_53 ? rd_53 :
		hit_54 ? rd_54 :
		hit_55 ? rd_55 :
		hit_56 ? rd_56 :
		hit_57 ? rd_57 :
		hit_58 ? tx_avg :
		8'h00;

	// Sampled in setup so the data comes from a flop in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (setup_rd)
			prdata <= {24'h000000, rd_val};
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_long_seed_wr: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && clk_en && hit_long |=> long_seed == $past(pwdata[7:0]))
		else $error("long seed write lost");

	a_short_seed_wr: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && clk_en && hit_short |=> active_seed == $past(pwdata[6:0]) ||
			seed_select)
		else $error("short seed not offered to scrambler");

	a_view_a_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_51 && view_sel |=> prdata[7:0] == $past(meas.noise_a))
		else $error("view a noise level wrong");

	a_view_b_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_51 && !view_sel |=>
			prdata[7:0] == $past(meas.loop_quality))
		else $error("view b signal quality wrong");

	a_test_bus_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_test |=> prdata == {24'h000000, $past(test_bus)})
		else $error("test bus readback wrong");

	a_crc_high_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_57 && !view_sel |=>
			prdata[7:0] == $past(meas.header_crc[15:8]))
		else $error("header crc high byte wrong");

	a_mp_count_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_56 && view_sel |=>
			prdata[7:0] == {4'h0, $past(mp_count)} && prdata[7:0] <= 8'h0f)
		else $error("multipath count wrong");

	a_sem_set: assert property (@(posedge pclk) disable iff (!presetn)
		avg_done |=> tx_power_updated ##1 (tx_power_updated || $past(sem_clr)))
		else $error("semaphore not set on update");

	a_sem_clear: assert property (@(posedge pclk) disable iff (!presetn)
		sem_clr && !avg_done |=> !tx_power_updated)
		else $error("semaphore not cleared by read");

	a_avg_period: assert property (@(posedge pclk) disable iff (!presetn)
		!avg_done |=> $stable(tx_avg))
		else $error("average changed between 64-sample blocks");

	a_ro_wr_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		acc_done && pwrite && hit_ro |=> $stable(long_seed) && $stable(short_view))
		else $error("write to read-only register changed state");

	// ------------------------------------------------------------
	// Per-view readback and hold checks
	// ------------------------------------------------------------

	// Every view-dependent slot is checked in both views
	a_noise_b_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_52 && view_sel |=>
		prdata[7:0] == $past(meas.noise_b))
		else $error("view a antenna two noise level wrong");

	a_signal_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_52 && !view_sel |=>
		prdata[7:0] == $past(meas.signal_field))
		else $error("view b signal field wrong");

	a_i_off_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_53 && view_sel |=>
		prdata[7:0] == $past(meas.i_offset))
		else $error("view a i offset wrong");

	a_service_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_53 && !view_sel |=>
		prdata[7:0] == $past(meas.service_field))
		else $error("view b service field wrong");

	a_q_off_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_54 && view_sel |=>
		prdata[7:0] == $past(meas.q_offset))
		else $error("view a q offset wrong");

	a_len_low_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_54 && !view_sel |=>
		prdata[7:0] == $past(meas.length_field[7:0]))
		else $error("view b length low byte wrong");

	a_mp_last_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_55 && view_sel |=>
		prdata[7:0] == $past(mp_last))
		else $error("view a multipath metric wrong");

	a_len_high_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_55 && !view_sel |=>
		prdata[7:0] == $past(meas.length_field[15:8]))
		else $error("view b length high byte wrong");

	a_crc_low_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_56 && !view_sel |=>
		prdata[7:0] == $past(meas.header_crc[7:0]))
		else $error("view b header crc low byte wrong");

	a_quality_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_57 && view_sel |=>
		prdata[7:0] == $past(meas.packet_quality))
		else $error("view a packet quality wrong");

	a_tx_pwr_read: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_58 |=>
		prdata[7:0] == $past(tx_avg))
		else $error("tx power readback wrong");

	a_long_rd_back: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && hit_long |=>
		prdata == {24'h000000, $past(long_seed)})
		else $error("long seed readback wrong");

	a_view_follow: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit_short |=>
		view_a == $past(pwdata[BRXS_VIEW_BIT]))
		else $error("view select does not follow write");

	// Unmapped reads must not leak a stale word onto the bus
	a_unmapped_data: assert property (@(posedge pclk) disable iff (!presetn)
		setup_rd && !mapped |=>
		prdata == 32'h00000000)
		else $error("unmapped read returned data");

	// A frozen block keeps both seeds, the average, the multipath history and the semaphore
	a_frozen_state: assert property (@(posedge pclk) disable iff (!presetn)
		!clk_en |=> $stable(long_seed) && $stable(short_view) &&
		$stable(tx_avg) && $stable(mp_hist) && $stable(sem))
		else $error("state moved while clock enable low");

	a_mp_hist_shift: assert property (@(posedge pclk) disable iff (!presetn)
		packet_done && clk_en |=>
		mp_hist[0] == $past(mp_over))
		else $error("multipath history missed a packet");

	a_hist_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(packet_done && clk_en) |=>
		$stable(mp_hist) && $stable(mp_last))
		else $error("multipath state changed without a packet");

	a_sem_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!sem && !avg_done |=>
		!tx_power_updated)
		else $error("semaphore set without an update");

	// ------------------------------------------------------------
	// Covers
	// ------------------------------------------------------------
	c_read_view_a: cover property (@(posedge pclk) disable iff (!presetn)
		setup_rd && view_sel && hit_55);

	c_sem_cycle: cover property (@(posedge pclk) disable iff (!presetn)
		avg_done ##[1:200] sem_clr);

	c_set_and_clear: cover property (@(posedge pclk) disable iff (!presetn)
		avg_done && sem_clr);

	c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
		pslverr);

endmodule
`default_nettype wire

// [tb_brxs_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_brxs_regs;
	import brxs_pkg::*;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [BRXS_AW-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [7:0] test_bus, mp_metric;
	brxs_meas_t meas;
	logic packet_done, tx_sample_valid, seed_select, view_a, tx_power_updated;
	logic [2:0] mp_threshold;
	logic signed [7:0] tx_sample;
	logic [6:0] active_seed;
	int n_mismatch, num_checks, va, mp_last, txavg;
	int hist[$];
	logic [7:0] sl, ss;
	logic [31:0] r;
	logic e;
	logic [95:0] rnd;
	brxs_regs brxs_regs_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .test_bus(test_bus), .meas(meas),
		.packet_done(packet_done), .mp_metric(mp_metric),
		.mp_threshold(mp_threshold), .tx_sample(tx_sample),
		.tx_sample_valid(tx_sample_valid), .seed_select(seed_select),
		.active_seed(active_seed), .view_a(view_a),
		.tx_power_updated(tx_power_updated));
	// Free-running bus clock, 4 ns period
	initial
	begin
		pclk = 0;
		forever #2 pclk = ~pclk;
	end
	// ------------------------------------------------------------
	// Bus tasks and reference model
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask
	// Idle edge after each transfer keeps psel from being driven twice at once
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [31:0] rd, output logic er);
		int k;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 50)
		begin
			n_mismatch++;
			give_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] x;
		logic y;
		apb(1, a, d, x, y);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] x, input string nm);
		logic [31:0] g;
		logic y;
		apb(0, a, 8'h00, g, y);
		chk(nm, {24'h000000, x}, g);
	endtask
	// Expected read-only value for slot i (0 = test bus) in the current view
	function automatic logic [7:0] exp_ro(input int i);
		int c;
		c = 0;
		foreach (hist[j])
			c += hist[j];
		case (i)
			0: return test_bus;
			1: return va ? meas.noise_a : meas.loop_quality;
			2: return va ? meas.noise_b : meas.signal_field;
			3: return va ? meas.i_offset : meas.service_field;
			4: return va ? meas.q_offset : meas.length_field[7:0];
			5: return va ? mp_last[7:0] : meas.length_field[15:8];
			6: return va ? c[7:0] : meas.header_crc[7:0];
			7: return va ? meas.packet_quality : meas.header_crc[15:8];
			default: return txavg[7:0];
		endcase
	endfunction
	task automatic packet(input logic [7:0] m);
		packet_done <= 1;
		mp_metric <= m;
		@(posedge pclk);
		packet_done <= 0;
		mp_last = m;
		hist.push_back(m[7:5] > mp_threshold);
		if (hist.size() > BRXS_MP_HIST)
			void'(hist.pop_front());
		@(posedge pclk);
	endtask
	task automatic tx_round();
		int sum;
		logic signed [7:0] s;
		sum = 0;
		repeat (64)
		begin
			s = 8'($urandom);
			tx_sample <= s;
			tx_sample_valid <= 1;
			sum += s;
			@(posedge pclk);
		end
		tx_sample_valid <= 0;
		txavg = sum >>> BRXS_AVG_SHIFT;
		@(posedge pclk);
		@(negedge pclk);
		chk("semaphore set", 1, tx_power_updated);
		@(posedge pclk);
		rd(12'h1d0, txavg[7:0], "tx power");
		@(negedge pclk);
		chk("semaphore clear", 0, tx_power_updated);
		@(posedge pclk);
		rd(12'h1d0, txavg[7:0], "tx power again");
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h23707bd6));
		{presetn, clk_en, psel, penable, pwrite, paddr, pwdata} = '0;
		{packet_done, mp_metric, tx_sample, tx_sample_valid, seed_select} = '0;
		clk_en = 1;
		pstrb = 4'hf;
		test_bus = 8'h00;
		meas = '0;
		mp_threshold = 3'h3;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk("view after reset", 0, view_a);
		rd(12'h180, 8'h00, "long seed reset");
		rd(12'h188, 8'h00, "short seed reset");
		$display("test reset done");
		sl = 8'($urandom) & 8'h7f; // software keeps the spare bit zero
		ss = 8'($urandom) & 8'h7f;
		wr(12'h180, sl);
		wr(12'h188, ss);
		rd(12'h180, sl, "long seed");
		rd(12'h188, ss, "short seed");
		pstrb <= 4'h0;
		wr(12'h180, 8'h55);
		pstrb <= 4'hf;
		rd(12'h180, sl, "strobe off write");
		seed_select <= 1;
		@(negedge pclk);
		chk("active long", sl[6:0], active_seed);
		@(posedge pclk);
		seed_select <= 0;
		@(negedge pclk);
		chk("active short", ss[6:0], active_seed);
		@(posedge pclk);
		$display("test seeds done");
		for (int v = 0; v < 2; v++)
		begin
			wr(12'h188, {v[0], ss[6:0]});
			va = v;
			rnd = {$urandom, $urandom, $urandom};
			meas <= rnd[87:0];
			test_bus <= 8'($urandom);
			@(posedge pclk);
			chk("view flag", v, view_a);
			for (int i = 0; i < 9; i++)
				rd(12'(12'h190 + 8 * i), exp_ro(i), "view read");
		end
		$display("test views done");
		for (int p = 0; p < 17; p++)
		begin
			packet(8'($urandom));
			rd(12'h1b8, mp_last[7:0], "multipath");
			rd(12'h1c0, exp_ro(6), "multipath count");
		end
		wr(12'h1b8, ~mp_last[7:0]);
		rd(12'h1b8, mp_last[7:0], "read-only write");
		apb(0, 12'h1d8, 8'h00, r, e);
		chk("unmapped err", 1, e);
		chk("unmapped data", 0, r);
		apb(0, 12'h181, 8'h00, r, e);
		chk("unaligned err", 1, e);
		$display("test multipath done");
		// Frozen block must ignore a full block of samples
		clk_en <= 0;
		tx_sample <= 8'h7f;
		tx_sample_valid <= 1;
		repeat (70) @(posedge pclk);
		chk("ready frozen", 0, pready);
		tx_sample_valid <= 0;
		clk_en <= 1;
		@(posedge pclk);
		chk("frozen semaphore", 0, tx_power_updated);
		$display("test freeze done");
		tx_round();
		tx_round();
		$display("test tx power done");
		give_verdict();
	end
endmodule
`default_nettype wire
